// File: uusl_regs.svh
// Register offsets, field positions, reset values and timing for the user-unit scaling block
`ifndef UUSL_REGS_SVH
`define UUSL_REGS_SVH

// Factor registers, one word each, index is addr[5:2]
`define UUSL_OFS_ENC_INC    8'h00
`define UUSL_OFS_MOT_REV    8'h04
`define UUSL_OFS_GEAR_MOT   8'h08
`define UUSL_OFS_GEAR_SHAFT 8'h0c
`define UUSL_OFS_FEED       8'h10
`define UUSL_OFS_FEED_REV   8'h14
`define UUSL_OFS_SPD_NUM    8'h18
`define UUSL_OFS_SPD_DEN    8'h1c
`define UUSL_OFS_ACC_NUM    8'h20
`define UUSL_OFS_ACC_DEN    8'h24
`define UUSL_OFS_JERK_NUM   8'h28
`define UUSL_OFS_JERK_DEN   8'h2c
`define UUSL_NUM_FAC        12
// Motion and limit registers
`define UUSL_OFS_TARGET     8'h30
`define UUSL_OFS_TOL_ZONE   8'h34
`define UUSL_OFS_SW_MIN     8'h38
`define UUSL_OFS_SW_MAX     8'h3c
`define UUSL_OFS_CTRL       8'h40
`define UUSL_OFS_STATUS     8'h44
`define UUSL_OFS_ACT_USER   8'h48
`define UUSL_OFS_RES        8'h4c
`define UUSL_OFS_GEAR       8'h50
`define UUSL_OFS_FEED_K     8'h54
`define UUSL_OFS_DEMAND     8'h58
// Scaled value table: user view at 0x80.., internal view at 0xc0..
`define UUSL_TAB_USER       2'b10
`define UUSL_TAB_INT        2'b11
`define UUSL_TAB_N          16
`define UUSL_TAB_SPD_LO     4'h0
`define UUSL_TAB_ACC_LO     4'h6
`define UUSL_TAB_JERK_LO    4'hc
// Reset values
`define UUSL_RST_ENC_INC    16'h07d0
`define UUSL_RST_ONE        16'h0001
`define UUSL_RST_SPD_DEN    16'h003c
// Fixed-point fraction of internal speed, acceleration, jerk and ratios
`define UUSL_FRAC           8
// Application cycle
`define UUSL_APP_CYCLE_NS   1000000
`define UUSL_CLK_NS         20
`endif

// File: uusl_pkg.sv
// Types shared by the user-unit scaling block
package uusl_pkg;
	// Control register layout
	typedef struct packed {
		logic fault_clear;
		logic sw_lim_en;
		logic hw_lim_pos_en;
		logic hw_lim_neg_en;
	} uusl_ctrl_t;
	// Status register layout
	typedef struct packed {
		logic busy;
		logic in_tol_pos;
		logic in_tol_neg;
		logic pos_hit;
		logic neg_hit;
		logic rejected;
		logic clamped;
		logic fault;
	} uusl_status_t;
	// Update sequencer states
	typedef enum logic [1:0] {
		UUSL_IDLE = 2'b00,
		UUSL_SNAP = 2'b01,
		UUSL_POS = 2'b10,
		UUSL_TAB = 2'b11
	} uusl_state_t;
endpackage

// File: uusl_scaler.sv
// User-unit scaling, software limits and limit-switch tolerance zones
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "uusl_regs.svh"
//
// What this block does
// - Virtual resolution is encoder increments over motor revolutions, zeros count as one.
// - Encoder increments reset to 2000, motor revolutions reset to one.
// - All positions are held in virtual encoder resolution, not physical encoder counts.
// - Gear ratio is motor over shaft revolutions; a zero factor becomes one.
// - Feed constant is feed over drive-axis revolutions; a zero factor becomes one.
// - Actual and target positions convert between user and internal units by all factors.
// - Speeds are held internally in rps: input times speed numerator over denominator.
// - Reported speed is the internal value divided by the speed factor.
// - Speed scaling covers ramp output, preset, homing, profile target/final, torque limit.
// - Accelerations held in rps squared, scaled by acceleration factor, zeros become one.
// - Acceleration scaling covers homing, profile, velocity-mode and quick-stop ramps.
// - Four jerk values scale to rps cubed by the jerk factor, zeros become one.
// - A configurable tolerance zone just past a limit switch permits free movement.
// - Entering the range past the tolerance zone stops at once and faults.
// - Targets are clamped to software limits; demand never exceeds those limits.
// - Outside the permitted range only commands toward that range are accepted.
// - Parameters and inputs are taken once per application cycle; earlier changes are lost.
// - Limit-switch inputs act only when enabled; software limits work besides them.
//
module uusl_scaler #(
	parameter int DW = 32,
	parameter int PW = 16,
	parameter int APP_CYCLES = `UUSL_APP_CYCLE_NS / `UUSL_CLK_NS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Motion core side, same clock domain
	input wire logic signed [DW-1:0] act_pos,
	input wire logic signed [DW-1:0] act_speed,
	output logic signed [DW-1:0] demand_pos,
	output logic demand_stb,
	output logic [`UUSL_TAB_N-1:0][DW-1:0] scaled,
	// Limit switch pins and stop
	input wire logic lim_neg_pin,
	input wire logic lim_pos_pin,
	output logic stop_req,
	output logic fault
);
	localparam int WW = DW + 3 * PW + `UUSL_FRAC + 2;
	localparam int TW = $clog2(APP_CYCLES + 1);

	// Replace a zero factor by one so that no divisor is ever zero
	function automatic logic [PW-1:0] nz(input logic [PW-1:0] v);
		return (v == '0) ? PW'(1) : v;
	endfunction

	// Product of three factors at full width
	function automatic logic [3*PW-1:0] prod3(input logic [PW-1:0] a, input logic [PW-1:0] b,
		input logic [PW-1:0] c);
		return (3*PW)'(a) * (3*PW)'(b) * (3*PW)'(c);
	endfunction

	// (v * n << lsh) / (d << rsh), truncated toward zero
	function automatic logic signed [DW-1:0] mdiv(input logic signed [DW-1:0] v,
		input logic [3*PW-1:0] n, input logic [3*PW-1:0] d, input int lsh, input int rsh);
		logic signed [WW-1:0] p;
		logic signed [WW-1:0] q;
		p = WW'(v);
		p = p * $signed(WW'(n));
		p = p <<< lsh;
		q = $signed(WW'(d)) <<< rsh;
		p = p / q;
		return p[DW-1:0];
	endfunction

	// Signed value of a factor for ratio readback
	function automatic logic signed [DW-1:0] sx(input logic [PW-1:0] f);
		return $signed(DW'(f));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Shadow registers written by software

	logic [PW-1:0] fac_sh [`UUSL_NUM_FAC];
	logic signed [DW-1:0] target_sh;
	logic signed [DW-1:0] tol_sh;
	logic signed [DW-1:0] sw_min_sh;
	logic signed [DW-1:0] sw_max_sh;
	logic cmd_sh;
	uusl_pkg::uusl_ctrl_t ctrl;
	logic signed [DW-1:0] user_tab [`UUSL_TAB_N];
	logic fault_clr_wr;
	logic cmd_take;

	// Working copies taken once per application cycle
	logic [PW-1:0] fac [`UUSL_NUM_FAC];
	logic signed [DW-1:0] target_w;
	logic signed [DW-1:0] tol_w;
	logic signed [DW-1:0] sw_min_w;
	logic signed [DW-1:0] sw_max_w;
	logic cmd_w;
	logic signed [DW-1:0] act_w;
	logic signed [DW-1:0] spd_w;
	logic neg_w;
	logic pos_w;

	// Derived values
	logic signed [DW-1:0] res_k;
	logic signed [DW-1:0] gear_k;
	logic signed [DW-1:0] feed_k;
	logic signed [DW-1:0] act_user;
	logic signed [DW-1:0] ramp_user;
	uusl_pkg::uusl_status_t st;
	uusl_pkg::uusl_state_t state;
	logic [3:0] idx;
	logic [TW-1:0] tick_cnt;
	logic tick;

	assign fault_clr_wr = wr && addr == `UUSL_OFS_CTRL && wdata[3];
	assign cmd_take = state == uusl_pkg::UUSL_SNAP;

	// Factor writes; a zero is stored and replaced only when used
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < `UUSL_NUM_FAC; i++) begin
				fac_sh[i] <= `UUSL_RST_ONE;
			end
			fac_sh[0] <= `UUSL_RST_ENC_INC;
			fac_sh[7] <= `UUSL_RST_SPD_DEN;
		end else if (wr && addr < `UUSL_OFS_TARGET) begin
			fac_sh[addr[5:2]] <= wdata[PW-1:0];
		end
	end

	// Motion and limit configuration writes
	always_ff @(posedge clk) begin
		if (!nrst) begin
			target_sh <= '0;
			tol_sh <= '0;
			sw_min_sh <= '0;
			sw_max_sh <= '0;
			ctrl <= '0;
		end else if (wr) begin
			case (addr)
				`UUSL_OFS_TARGET: target_sh <= $signed(wdata[DW-1:0]);
				`UUSL_OFS_TOL_ZONE: tol_sh <= $signed(wdata[DW-1:0]);
				`UUSL_OFS_SW_MIN: sw_min_sh <= $signed(wdata[DW-1:0]);
				`UUSL_OFS_SW_MAX: sw_max_sh <= $signed(wdata[DW-1:0]);
				`UUSL_OFS_CTRL: ctrl <= uusl_pkg::uusl_ctrl_t'({1'b0, wdata[2:0]});
				default: ;
			endcase
		end
	end

	// Travel command: a target write raises it, the snapshot consumes it
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cmd_sh <= 1'b0;
		end else if (wr && addr == `UUSL_OFS_TARGET) begin
			cmd_sh <= 1'b1; // Write wins over the consume in the same cycle
		end else if (cmd_take) begin
			cmd_sh <= 1'b0;
		end
	end

	// User view of the table; slot 0 is the ramp output and not writable
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < `UUSL_TAB_N; i++) begin
				user_tab[i] <= '0;
			end
		end else if (wr && addr[7:6] == `UUSL_TAB_USER && addr[5:2] != `UUSL_TAB_SPD_LO) begin
			user_tab[addr[5:2]] <= $signed(wdata[DW-1:0]);
		end else if (state == uusl_pkg::UUSL_POS) begin
			user_tab[`UUSL_TAB_SPD_LO] <= ramp_user;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Application cycle and pin synchronisers

	logic neg_m, neg_s, pos_m, pos_s;

	// Divider giving a one-cycle tick each application cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else if (tick_cnt == TW'(APP_CYCLES - 1)) begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + TW'(1);
			tick <= 1'b0;
		end
	end

	// Limit switch pins come from outside: two flops before use
	always_ff @(posedge clk) begin
		if (!nrst) begin
			neg_m <= 1'b0;
			neg_s <= 1'b0;
			pos_m <= 1'b0;
			pos_s <= 1'b0;
		end else begin
			neg_m <= lim_neg_pin;
			neg_s <= neg_m;
			pos_m <= lim_pos_pin;
			pos_s <= pos_m;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Update sequencer: snapshot, positions, then one table slot per clock

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= uusl_pkg::UUSL_IDLE;
			idx <= '0;
		end else begin
			unique case (state)
				uusl_pkg::UUSL_IDLE: if (tick) state <= uusl_pkg::UUSL_SNAP;
				uusl_pkg::UUSL_SNAP: state <= uusl_pkg::UUSL_POS;
				uusl_pkg::UUSL_POS: begin
					state <= uusl_pkg::UUSL_TAB;
					idx <= '0;
				end
				uusl_pkg::UUSL_TAB: begin
					idx <= idx + 4'h1;
					if (idx == 4'(`UUSL_TAB_N - 1)) state <= uusl_pkg::UUSL_IDLE;
				end
			endcase
		end
	end

	// Snapshot: changes between two snapshots collapse to the last one
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < `UUSL_NUM_FAC; i++) begin
				fac[i] <= `UUSL_RST_ONE;
			end
			fac[0] <= `UUSL_RST_ENC_INC;
			fac[7] <= `UUSL_RST_SPD_DEN;
			target_w <= '0;
			tol_w <= '0;
			sw_min_w <= '0;
			sw_max_w <= '0;
			cmd_w <= 1'b0;
			act_w <= '0;
			spd_w <= '0;
			neg_w <= 1'b0;
			pos_w <= 1'b0;
		end else if (state == uusl_pkg::UUSL_SNAP) begin
			for (int i = 0; i < `UUSL_NUM_FAC; i++) begin
				fac[i] <= nz(fac_sh[i]);
			end
			target_w <= target_sh;
			tol_w <= tol_sh;
			sw_min_w <= sw_min_sh;
			sw_max_w <= sw_max_sh;
			cmd_w <= cmd_sh;
			act_w <= act_pos;
			spd_w <= act_speed;
			neg_w <= neg_s && ctrl.hw_lim_neg_en;
			pos_w <= pos_s && ctrl.hw_lim_pos_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Position scaling and software limits

	logic [3*PW-1:0] pos_n, pos_d;
	logic signed [DW-1:0] tgt_i, min_i, max_i, tol_i;
	logic outside_lo, outside_hi, toward, accept;
	logic signed [DW-1:0] clamp_t, clamp_d;
	logic clamped_q, rejected_q;

	// Increments per user unit: enc * gear / (mot * feed), all zero-safe
	assign pos_n = prod3(fac[0], fac[2], fac[5]);
	assign pos_d = prod3(fac[1], fac[3], fac[4]);
	assign tgt_i = mdiv(target_w, pos_n, pos_d, 0, 0);
	assign min_i = mdiv(sw_min_w, pos_n, pos_d, 0, 0);
	assign max_i = mdiv(sw_max_w, pos_n, pos_d, 0, 0);
	assign tol_i = mdiv(tol_w, pos_n, pos_d, 0, 0);
	assign outside_lo = ctrl.sw_lim_en && act_w < min_i;
	assign outside_hi = ctrl.sw_lim_en && act_w > max_i;
	// Outside the range, only a move that heads back in is taken
	assign toward = (outside_lo && tgt_i > act_w) || (outside_hi && tgt_i < act_w);
	assign accept = !(outside_lo || outside_hi) || toward;
	assign clamp_t = !ctrl.sw_lim_en ? tgt_i : (tgt_i < min_i) ? min_i :
		(tgt_i > max_i) ? max_i : tgt_i;
	// Standing demand is re-clamped so a tightened limit also binds it
	assign clamp_d = !ctrl.sw_lim_en ? demand_pos : (demand_pos < min_i) ? min_i :
		(demand_pos > max_i) ? max_i : demand_pos;

	// Demand position and command strobe
	always_ff @(posedge clk) begin
		if (!nrst) begin
			demand_pos <= '0;
			demand_stb <= 1'b0;
			clamped_q <= 1'b0;
			rejected_q <= 1'b0;
		end else if (state == uusl_pkg::UUSL_POS) begin
			if (cmd_w && accept && !fault) begin
				demand_pos <= clamp_t;
				demand_stb <= 1'b1;
				clamped_q <= clamp_t != tgt_i;
				rejected_q <= 1'b0;
			end else begin
				demand_pos <= clamp_d;
				demand_stb <= 1'b0;
				clamped_q <= clamp_d != demand_pos;
				rejected_q <= rejected_q || cmd_w; // A refusal stays flagged until one is taken
			end
		end else begin
			demand_stb <= 1'b0;
		end
	end

	// Reported position, ratios and ramp speed in user units
	always_ff @(posedge clk) begin
		if (!nrst) begin
			act_user <= '0;
			ramp_user <= '0;
			res_k <= '0;
			gear_k <= '0;
			feed_k <= '0;
		end else if (state == uusl_pkg::UUSL_POS) begin
			act_user <= mdiv(act_w, pos_d, pos_n, 0, 0);
			ramp_user <= mdiv(spd_w, (3*PW)'(fac[7]), (3*PW)'(fac[6]), 0, `UUSL_FRAC);
			res_k <= mdiv(sx(fac[0]), (3*PW)'(1), (3*PW)'(fac[1]), `UUSL_FRAC, 0);
			gear_k <= mdiv(sx(fac[2]), (3*PW)'(1), (3*PW)'(fac[3]), `UUSL_FRAC, 0);
			feed_k <= mdiv(sx(fac[4]), (3*PW)'(1), (3*PW)'(fac[5]), `UUSL_FRAC, 0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Speed, acceleration and jerk table, one slot per clock to share a divider

	logic [PW-1:0] t_num, t_den;

	// Pick the factor pair that belongs to the slot class
	always_comb begin
		if (idx >= `UUSL_TAB_JERK_LO) begin
			t_num = fac[10];
			t_den = fac[11];
		end else if (idx >= `UUSL_TAB_ACC_LO) begin
			t_num = fac[8];
			t_den = fac[9];
		end else begin
			t_num = fac[6];
			t_den = fac[7];
		end
	end

	// Internal values: slot 0 follows the measured speed, others the user input
	always_ff @(posedge clk) begin
		if (!nrst) begin
			scaled <= '0;
		end else if (state == uusl_pkg::UUSL_TAB) begin
			if (idx == `UUSL_TAB_SPD_LO) begin
				scaled[idx] <= spd_w;
			end else begin
				scaled[idx] <= mdiv(user_tab[idx], (3*PW)'(t_num), (3*PW)'(t_den),
					`UUSL_FRAC, 0);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Limit switches, tolerance zones and fault

	logic signed [DW-1:0] edge_neg, edge_pos;
	logic neg_lat, pos_lat, forbid;

	// Forbidden once past the switch point by more than the zone length
	assign forbid = (neg_lat && act_w < edge_neg - tol_i) ||
		(pos_lat && act_w > edge_pos + tol_i);

	// Latch the position where each enabled switch was first seen active
	always_ff @(posedge clk) begin
		if (!nrst) begin
			edge_neg <= '0;
			edge_pos <= '0;
			neg_lat <= 1'b0;
			pos_lat <= 1'b0;
		end else if (state == uusl_pkg::UUSL_POS) begin
			if (neg_w && !neg_lat) edge_neg <= act_w;
			if (pos_w && !pos_lat) edge_pos <= act_w;
			neg_lat <= neg_w;
			pos_lat <= pos_w;
		end
	end

	// Fault and stop; a forbidden position outweighs a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fault <= 1'b0;
			stop_req <= 1'b0;
		end else if (state == uusl_pkg::UUSL_TAB && idx == 4'h0 && forbid) begin
			fault <= 1'b1;
			stop_req <= 1'b1;
		end else if (fault_clr_wr) begin
			fault <= 1'b0;
			stop_req <= 1'b0;
		end
	end

	// Status bits that mirror limit and sequencer state
	always_comb begin
		st.fault = fault;
		st.clamped = clamped_q;
		st.rejected = rejected_q;
		st.neg_hit = neg_lat;
		st.pos_hit = pos_lat;
		st.in_tol_neg = neg_lat && !forbid;
		st.in_tol_pos = pos_lat && !forbid;
		st.busy = state != uusl_pkg::UUSL_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after the read strobe

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata <= '0;
		end else if (rd) begin
			if (addr[7:6] == `UUSL_TAB_USER) begin
				rdata <= 32'(user_tab[addr[5:2]]);
			end else if (addr[7:6] == `UUSL_TAB_INT) begin
				rdata <= 32'(scaled[addr[5:2]]);
			end else if (addr < `UUSL_OFS_TARGET) begin
				rdata <= 32'(fac_sh[addr[5:2]]);
			end else begin
				case (addr)
					`UUSL_OFS_TARGET: rdata <= 32'(target_sh);
					`UUSL_OFS_TOL_ZONE: rdata <= 32'(tol_sh);
					`UUSL_OFS_SW_MIN: rdata <= 32'(sw_min_sh);
					`UUSL_OFS_SW_MAX: rdata <= 32'(sw_max_sh);
					`UUSL_OFS_CTRL: rdata <= 32'(ctrl);
					`UUSL_OFS_STATUS: rdata <= 32'(st);
					`UUSL_OFS_ACT_USER: rdata <= 32'(act_user);
					`UUSL_OFS_RES: rdata <= 32'(res_k);
					`UUSL_OFS_GEAR: rdata <= 32'(gear_k);
					`UUSL_OFS_FEED_K: rdata <= 32'(feed_k);
					`UUSL_OFS_DEMAND: rdata <= 32'(demand_pos);
					default: rdata <= '0; // Unmapped reads return zero
				endcase
			end
		end else begin
			rdata <= '0;
		end
	end

endmodule // uusl_scaler

// File: uusl_scaler_checker.sv
// Concurrent checks on the ports of the user-unit scaling block
`timescale 1ns/1ps
`include "uusl_regs.svh"
module uusl_scaler_checker #(
	parameter int DW = 32,
	parameter int PW = 16,
	parameter int APP_CYCLES = 50000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	// Motion and limit outputs
	input wire logic signed [DW-1:0] demand_pos,
	input wire logic demand_stb,
	input wire logic stop_req,
	input wire logic fault
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic clr_wr;
	logic [31:0] since_stb;
	////////////////////////////////////////////////////////////////////////
	// Fault clear strobe seen on the register port
	assign clr_wr = wr && addr == `UUSL_OFS_CTRL && wdata[3];
	// Cycles since the last accepted command, saturating so reset counts as long ago
	always_ff @(posedge clk) begin
		if (!nrst) begin
			since_stb <= 32'(APP_CYCLES);
		end else if (demand_stb) begin
			since_stb <= 32'h0;
		end else if (since_stb < 32'(APP_CYCLES)) begin
			since_stb <= since_stb + 32'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Named steps of a register read and of the command strobe pulse
	sequence s_read(logic [7:0] a);
		rd && addr == a;
	endsequence
	sequence s_pulse;
		demand_stb ##1 !demand_stb;
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0) !nrst |=> (rdata == 32'h0 && !fault
		&& !stop_req && !demand_stb && demand_pos == '0)) else $error("outputs not cleared by reset");
	chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside the answer cycle");
	chk_unmapped_zero: assert property (s_read(8'h7c) |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_clear_reads_zero: assert property (s_read(`UUSL_OFS_CTRL) |=> !rdata[3])
		else $error("fault clear bit reads back");
	chk_status_fault: assert property (s_read(`UUSL_OFS_STATUS) |=> rdata[0] == $past(fault))
		else $error("status fault differs from fault output");
	chk_stb_pulse: assert property (demand_stb |-> s_pulse)
		else $error("command strobe longer than one cycle");
	chk_stb_spacing: assert property (demand_stb |-> since_stb >= 32'(APP_CYCLES - 1))
		else $error("two commands within one application cycle");
	chk_fault_hold: assert property (fault && !clr_wr |=> fault)
		else $error("fault dropped without a clear");
	chk_stop_fault: assert property (stop_req == fault)
		else $error("stop request and fault disagree");
	chk_fault_no_cmd: assert property (fault |-> !demand_stb)
		else $error("command accepted in fault state");
endmodule // uusl_scaler_checker
bind uusl_scaler uusl_scaler_checker #(.DW(DW), .PW(PW), .APP_CYCLES(APP_CYCLES)) u_chk (
	.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.demand_pos(demand_pos), .demand_stb(demand_stb), .stop_req(stop_req), .fault(fault));

// File: uusl_motion_model.sv
// Behavioural motion core with limit switches, facing the scaling block
`timescale 1ns/1ps
module uusl_motion_model #(
	parameter int DW = 32,
	parameter logic signed [31:0] POS_SWITCH = 32'sh000003e8,
	parameter logic signed [31:0] NEG_SWITCH = -32'sh000003e8,
	parameter logic signed [31:0] SPEED = 32'sh00000500
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bench control
	input wire logic load,
	input wire logic signed [DW-1:0] load_pos,
	input wire logic slow,
	// Block side
	input wire logic signed [DW-1:0] demand_pos,
	input wire logic demand_stb,
	output logic signed [DW-1:0] act_pos,
	output logic signed [DW-1:0] act_speed,
	output logic lim_neg_pin,
	output logic lim_pos_pin
);
	logic signed [DW-1:0] goal;
	////////////////////////////////////////////////////////////////////////
	// Follow accepted demands at once, or one increment a cycle to model a slow axis
	always_ff @(posedge clk) begin
		if (!nrst) begin
			act_pos <= '0;
			goal <= '0;
		end else if (load) begin
			act_pos <= load_pos;
			goal <= load_pos;
		end else begin
			if (demand_stb) begin
				goal <= demand_pos;
			end
			if (!slow) begin
				act_pos <= demand_stb ? demand_pos : goal;
			end else if (act_pos < goal) begin
				act_pos <= act_pos + 1;
			end else if (act_pos > goal) begin
				act_pos <= act_pos - 1;
			end
		end
	end
	// Switches stay actuated all the way past their mounting point
	assign lim_pos_pin = act_pos >= POS_SWITCH;
	assign lim_neg_pin = act_pos <= NEG_SWITCH;
	assign act_speed = SPEED; // Constant 5 rps keeps the ramp slot predictable
endmodule // uusl_motion_model

// File: testbench.sv
// Self-checking testbench for the user-unit scaling block
`timescale 1ns/1ps
`include "uusl_regs.svh"
module testbench;
	localparam int APPC = 40;
	localparam int SETTLE = 2 * APPC + 30;
	localparam int LIMIT = 20000;
	logic clk, nrst, wr, rd, load, slow, demand_stb, lim_neg_pin, lim_pos_pin, stop_req, fault, got;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic signed [31:0] act_pos, act_speed, demand_pos, load_pos;
	logic [15:0][31:0] scaled;
	int err_count, comparisons, cyc;
	////////////////////////////////////////////////////////////////////////
	uusl_scaler #(.APP_CYCLES(APPC)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .act_pos(act_pos), .act_speed(act_speed),
		.demand_pos(demand_pos), .demand_stb(demand_stb), .scaled(scaled),
		.lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin), .stop_req(stop_req), .fault(fault));
	uusl_motion_model u_core (.clk(clk), .nrst(nrst), .load(load), .load_pos(load_pos),
		.slow(slow), .demand_pos(demand_pos), .demand_stb(demand_stb), .act_pos(act_pos),
		.act_speed(act_speed), .lim_neg_pin(lim_neg_pin), .lim_pos_pin(lim_pos_pin));
	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_count++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One-cycle register write and read; read data stand only in the next cycle
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Bounded wait for an accepted command, up to two application cycles plus ten clocks
	task automatic wait_stb(output logic g);
		g = 1'b0;
		repeat (2 * APPC + 10) begin
			@(posedge clk);
			#1;
			if (demand_stb === 1'b1) begin
				g = 1'b1;
				break;
			end
		end
	endtask
	task automatic mv(input logic signed [31:0] p);
		@(posedge clk);
		load <= 1'b1;
		load_pos <= p;
		@(posedge clk);
		load <= 1'b0;
	endtask
	task automatic settle();
		repeat (SETTLE) @(posedge clk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		{wr, rd, load, slow} = 4'h0;
		addr = 8'h00;
		wdata = 32'h0;
		load_pos = 32'sh0;
		err_count = 0;
		comparisons = 0;
		cyc = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		// Reset values and an unmapped hole
		rreg(`UUSL_OFS_ENC_INC, rv); chk_word(rv, 32'h000007d0);
		rreg(`UUSL_OFS_MOT_REV, rv); chk_word(rv, 32'h00000001);
		rreg(`UUSL_OFS_SPD_DEN, rv); chk_word(rv, 32'h0000003c);
		rreg(8'h7c, rv); chk_word(rv, 32'h0);
		settle();
		rreg(`UUSL_OFS_RES, rv); chk_word(rv, 32'h0007d000);
		// Zero factors stand in as one; position scale uses every factor
		wreg(`UUSL_OFS_ENC_INC, 32'h00000bb8);
		wreg(`UUSL_OFS_MOT_REV, 32'h0);
		wreg(`UUSL_OFS_GEAR_MOT, 32'h00000003);
		wreg(`UUSL_OFS_GEAR_SHAFT, 32'h0);
		wreg(`UUSL_OFS_FEED, 32'h0);
		wreg(`UUSL_OFS_FEED_REV, 32'h00000005);
		mv(32'sh0006ddd0);
		settle();
		rreg(`UUSL_OFS_MOT_REV, rv); chk_word(rv, 32'h0);
		rreg(`UUSL_OFS_RES, rv); chk_word(rv, 32'h000bb800);
		rreg(`UUSL_OFS_GEAR, rv); chk_word(rv, 32'h00000300);
		rreg(`UUSL_OFS_FEED_K, rv); chk_word(rv, 32'h00000033);
		rreg(`UUSL_OFS_ACT_USER, rv); chk_word(rv, 32'h0000000a);
		wreg(`UUSL_OFS_TARGET, 32'h0000000a);
		wait_stb(got); chk_bit(got, 1'b1);
		chk_word(demand_pos, 32'h0006ddd0);
		// Every speed, acceleration and jerk slot, with zero factors replaced
		wreg(`UUSL_OFS_ACC_NUM, 32'h0);
		wreg(`UUSL_OFS_ACC_DEN, 32'h0000003c);
		wreg(`UUSL_OFS_JERK_NUM, 32'h00000003);
		wreg(`UUSL_OFS_JERK_DEN, 32'h0);
		for (int i = 1; i < 16; i++) begin
			wreg(8'h80 + 8'(4 * i), i < 6 ? 32'h12c : (i < 12 ? 32'h258 : 32'h5));
		end
		settle();
		for (int i = 1; i < 16; i++) begin
			chk_word(scaled[i], i < 6 ? 32'h500 : (i < 12 ? 32'ha00 : 32'hf00));
		end
		chk_word(scaled[0], 32'h00000500);
		rreg(8'hc4, rv); chk_word(rv, 32'h00000500);
		rreg(8'h80, rv); chk_word(rv, 32'h0000012c);
		// Software limits with unity scale, slow axis first
		wreg(`UUSL_OFS_ENC_INC, 32'h1);
		wreg(`UUSL_OFS_GEAR_MOT, 32'h1);
		wreg(`UUSL_OFS_FEED_REV, 32'h1);
		wreg(`UUSL_OFS_SW_MIN, 32'hffffff9c);
		wreg(`UUSL_OFS_SW_MAX, 32'h00000064);
		wreg(`UUSL_OFS_CTRL, 32'h4);
		mv(32'sh0);
		slow <= 1'b1;
		settle();
		wreg(`UUSL_OFS_TARGET, 32'h000001f4);
		wait_stb(got); chk_bit(got, 1'b1);
		chk_word(demand_pos, 32'h00000064);
		rreg(`UUSL_OFS_STATUS, rv); chk_bit(rv[1], 1'b1);
		wreg(`UUSL_OFS_TARGET, 32'hfffffe0c);
		wreg(`UUSL_OFS_TARGET, 32'hffffffce);
		wait_stb(got); chk_word(demand_pos, 32'hffffffce);
		wait_stb(got); chk_bit(got, 1'b0);
		// Axis outside the range: only commands toward it are taken
		slow <= 1'b0;
		mv(32'sh000000c8);
		settle();
		wreg(`UUSL_OFS_TARGET, 32'h0000012c);
		wait_stb(got); chk_bit(got, 1'b0);
		rreg(`UUSL_OFS_STATUS, rv); chk_bit(rv[2], 1'b1);
		wreg(`UUSL_OFS_TARGET, 32'h00000032);
		wait_stb(got); chk_word(demand_pos, 32'h00000032);
		// Limit switch: disabled, tolerance zone, then forbidden range
		wreg(`UUSL_OFS_CTRL, 32'h0);
		wreg(`UUSL_OFS_TOL_ZONE, 32'h00000014);
		mv(32'sh0000044c);
		settle();
		chk_bit(fault, 1'b0);
		mv(32'sh0);
		wreg(`UUSL_OFS_CTRL, 32'h2);
		settle();
		mv(32'sh000003e8);
		settle();
		mv(32'sh000003f2);
		settle();
		chk_bit(fault, 1'b0);
		mv(32'sh0000041a);
		settle();
		chk_bit(fault, 1'b1);
		chk_bit(stop_req, 1'b1);
		wreg(`UUSL_OFS_TARGET, 32'h0);
		wait_stb(got); chk_bit(got, 1'b0);
		mv(32'sh0);
		settle();
		chk_bit(fault, 1'b1);
		wreg(`UUSL_OFS_CTRL, 32'h8);
		repeat (3) @(posedge clk);
		#1;
		chk_bit(fault, 1'b0);
		chk_bit(stop_req, 1'b0);
		// Negative switch: latched at first contact, forbidden past the zone
		wreg(`UUSL_OFS_CTRL, 32'h1);
		mv(-32'sh0000041a);
		settle();
		mv(-32'sh00000438);
		settle();
		chk_bit(fault, 1'b1);
		summarize();
	end
endmodule // testbench
